// *** hw/cgc_defines.svh ***
// Constants of the clock generator control block: I2C slave address,
// command codes, register map, field positions and timing counts.
// Assumes inclusion by bare name from the package and the modules.
`ifndef CGC_DEFINES_SVH
`define CGC_DEFINES_SVH

// ****************************************
// I2C slave
// ****************************************
`define CGC_SLAVE_ADDR 7'h6a
`define CGC_CMD_WRITE 2'h0
`define CGC_CMD_STORE 2'h1
`define CGC_CMD_LOAD 2'h2
// Identification byte: value is arbitrary
`define CGC_ID_BYTE 8'h5a

// ****************************************
// Register map (byte index)
// ****************************************
`define CGC_NREG 32
`define CGC_IDX_W 5
`define CGC_REG_RST 8'h00
`define CGC_REG_SRC 5'h00
`define CGC_REG_PIN 5'h02
`define CGC_REG_ACT 5'h08
`define CGC_REG_GATE 5'h10
`define CGC_SRC_BYP 0
`define CGC_SRC_PRIM 1
`define CGC_SRC_MODE 3:2
`define CGC_PIN_POL 0
`define CGC_PIN_ROLE 1
`define CGC_NOUT 5
`define CGC_NCFG 6

// ****************************************
// Timing
// ****************************************
`define CGC_CLK_MHZ 125
`define CGC_NVM_BYTE_NS 1000
`define CGC_NVM_BYTE_CYC \
  ((`CGC_NVM_BYTE_NS * `CGC_CLK_MHZ + 999) / 1000)
`define CGC_TMR_W 8
`define CGC_LOSS_EDGES 4'h8

`endif

// *** hw/cgc_pkg.sv ***
// Types shared by the control block and its memory sequencer.
// Assumes cgc_defines.svh is on the include path.
`include "cgc_defines.svh"

package cgc_pkg;

  typedef enum logic [2:0] {
    CGC_IDLE,
    CGC_RX,
    CGC_ACK,
    CGC_TX,
    CGC_MACK,
    CGC_NEXT,
    CGC_WAIT
  } cgc_i2c_e;

  typedef logic [`CGC_NREG-1:0][7:0] cgc_regs_t;

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    cgc_i2c_e st;
    logic [7:0] shr;
    logic [3:0] bcnt;
    logic [1:0] bno;
    logic rd;
    logic [1:0] pend;
    logic [7:0] ptr;
    logic sda_oe_n;
    cgc_regs_t regs;
    logic [2:0] cfg;
    logic on_sec;
    logic [3:0] lx;
    logic [3:0] la;
    logic [`CGC_NOUT-1:0] pin_gated_bit;
    logic [`CGC_NOUT-1:0] ohz;
    logic [`CGC_NOUT-1:0] osp;
    logic pdn;
    logic ref_aux;
    logic nvm_go;
    logic nvm_store;
  } cgc_ctl_s;

  typedef struct packed {
    logic run;
    logic store;
    logic [`CGC_IDX_W-1:0] idx;
    logic [`CGC_TMR_W-1:0] tmr;
    cgc_regs_t mem;
  } cgc_nvm_s;

endpackage

// *** hw/cgc_nvm_if.sv ***
// Link between the control block and its non-volatile memory sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`include "cgc_defines.svh"

interface cgc_nvm_if;
  logic start;
  logic store;
  logic busy;
  logic [`CGC_IDX_W-1:0] idx;
  logic [7:0] rd_byte;
  logic ld_we;
  logic [7:0] ld_byte;

  modport ctrl (
    output start,
    output store,
    output rd_byte,
    input busy,
    input idx,
    input ld_we,
    input ld_byte
  );

  modport mem (
    input start,
    input store,
    input rd_byte,
    output busy,
    output idx,
    output ld_we,
    output ld_byte
  );
endinterface

// *** hw/cgc_nvm.sv ***
// Non-volatile store of the configuration registers and the sequencer
// that copies it to or from them, one byte per programming interval.
// Assumes the caller raises start only while busy is low.
`timescale 1ns/1ps
`include "cgc_defines.svh"

module cgc_nvm (
  input wire logic i_clk,
  input wire logic i_rst_n,
  cgc_nvm_if.mem nif
);

  cgc_pkg::cgc_nvm_s q_q;
  cgc_pkg::cgc_nvm_s d_d;
  localparam logic [`CGC_TMR_W-1:0] LAST =
    `CGC_TMR_W'(`CGC_NVM_BYTE_CYC - 1);
  localparam logic [`CGC_IDX_W-1:0] TOP = `CGC_IDX_W'(`CGC_NREG - 1);

  logic done;
  assign done = q_q.run && (q_q.tmr == LAST);
  assign nif.busy = q_q.run;
  assign nif.idx = q_q.idx;
  assign nif.ld_byte = q_q.mem[q_q.idx];
  assign nif.ld_we = done && !q_q.store;

  always_comb begin
    d_d = q_q;
    if (!q_q.run) begin
      if (nif.start) begin
        d_d.run = 1'b1;
        d_d.store = nif.store;
        d_d.idx = '0;
        d_d.tmr = '0;
      end
    end else if (done) begin
      // Whole register file is copied in every operation
      if (q_q.store) begin
        d_d.mem[q_q.idx] = nif.rd_byte;
      end
      d_d.tmr = '0;
      d_d.idx = q_q.idx + 1'b1;
      if (q_q.idx == TOP) begin
        d_d.run = 1'b0;
      end
    end else begin
      d_d.tmr = q_q.tmr + 1'b1;
    end
  end

  // A load runs straight out of reset, as at power-up
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_q <= '0;
      q_q.run <= 1'b1;
    end else begin
      q_q <= d_d;
    end
  end

endmodule // cgc_nvm

// *** hw/cgc_ctrl.sv ***
// Control logic of the programmable clock generator: I2C slave with
// auto-incrementing register pointer, store/load commands to the
// non-volatile memory, configuration select, reference choice with
// switchover, and the shutdown/output-enable pin truth table.
// Assumes SCL/SDA and all pins are asynchronous to I_SYS_CLK and
// that SCL is far slower than the system clock.
`timescale 1ns/1ps
`include "cgc_defines.svh"

module cgc_ctrl (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE_N,
  input wire logic I_XREF_CLK,
  input wire logic I_AUX_CLK,
  input wire logic I_SRC_PICK,
  input wire logic I_SHDN_GATE,
  input wire logic [2:0] I_CFG_PICK,
  output logic [2:0] O_CFG_PICK,
  output logic O_XTAL_BYPASS,
  output logic O_REF_AUX,
  output logic O_ON_SECONDARY,
  output logic O_PLL_SHUTDOWN,
  output logic [`CGC_NOUT-1:0] O_OUT_EN,
  output logic [`CGC_NOUT-1:0] O_OUT_HIZ,
  output logic [`CGC_NOUT-1:0] O_OUT_SUSP,
  output logic O_NVM_BUSY
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] reg_at(
    input cgc_pkg::cgc_regs_t regs,
    input logic [7:0] idx
  );
    logic [7:0] v;
    v = 8'h00;
    if (idx < 8'(`CGC_NREG)) begin
      v = regs[idx[`CGC_IDX_W-1:0]];
    end
    return v;
  endfunction

  // Rising edge of a synchronised input bit
  function automatic logic rise(
    input logic [8:0] now,
    input logic [8:0] old,
    input int unsigned b
  );
    return now[b] && !old[b];
  endfunction

  cgc_pkg::cgc_ctl_s q_q;
  cgc_pkg::cgc_ctl_s d_d;

  cgc_nvm_if nif ();

  cgc_nvm u_nvm (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .nif(nif)
  );

  // Pin bundle: 0 scl, 1 sda, 2 xref, 3 aux, 4 pick, 5 gate, 8:6 cfg
  logic [8:0] pins;
  assign pins = {I_CFG_PICK, I_SHDN_GATE, I_SRC_PICK, I_AUX_CLK,
                 I_XREF_CLK, I_SDA, I_SCL};

  logic scl;
  logic sda;
  logic scl_r;
  logic scl_f;
  logic start_c;
  logic stop_c;
  logic busy;
  logic [7:0] src_reg;
  logic [7:0] pin_reg;
  logic [7:0] act_reg;
  logic [7:0] gate_reg;
  logic prim_lost;
  logic sec_lost;
  logic x_lost;
  logic a_lost;
  logic gate_pin;
  logic pin_active;

  assign scl = q_q.s2[0];
  assign sda = q_q.s2[1];
  assign scl_r = rise(q_q.s2, q_q.s3, 0);
  assign scl_f = rise(q_q.s3, q_q.s2, 0);
  assign start_c = scl && q_q.s3[0] && q_q.s3[1] && !sda;
  assign stop_c = scl && q_q.s3[0] && !q_q.s3[1] && sda;
  // Busy covers the cycle between the go pulse and the sequencer start
  assign busy = nif.busy || q_q.nvm_go;

  assign src_reg = q_q.regs[`CGC_REG_SRC];
  assign pin_reg = q_q.regs[`CGC_REG_PIN];
  assign act_reg = q_q.regs[`CGC_REG_ACT + `CGC_IDX_W'(q_q.cfg)];
  assign gate_reg = q_q.regs[`CGC_REG_GATE + `CGC_IDX_W'(q_q.cfg)];
  assign x_lost = (q_q.lx == `CGC_LOSS_EDGES);
  assign a_lost = (q_q.la == `CGC_LOSS_EDGES);
  assign prim_lost = src_reg[`CGC_SRC_PRIM] ? a_lost : x_lost;
  assign sec_lost = src_reg[`CGC_SRC_PRIM] ? x_lost : a_lost;
  assign gate_pin = q_q.s2[5];
  assign pin_active = pin_reg[`CGC_PIN_POL] ? gate_pin : !gate_pin;

  assign nif.start = q_q.nvm_go;
  assign nif.store = q_q.nvm_store;
  assign nif.rd_byte = q_q.regs[nif.idx];

  always_comb begin
    d_d = q_q;
    d_d.s1 = pins;
    d_d.s2 = q_q.s1;
    d_d.s3 = q_q.s2;
    d_d.nvm_go = 1'b0;

    // ****************************************
    // I2C slave
    // ****************************************
    if (start_c) begin
      // Repeated start is accepted in any state
      d_d.st = cgc_pkg::CGC_RX;
      d_d.bcnt = 4'h0;
      d_d.bno = 2'h0;
      d_d.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      d_d.st = cgc_pkg::CGC_IDLE;
      d_d.sda_oe_n = 1'b1;
      if (q_q.pend != `CGC_CMD_WRITE && !busy) begin
        d_d.nvm_go = 1'b1;
        d_d.nvm_store = (q_q.pend == `CGC_CMD_STORE);
      end
      d_d.pend = `CGC_CMD_WRITE;
    end else begin
      unique case (q_q.st)
        cgc_pkg::CGC_IDLE, cgc_pkg::CGC_WAIT: begin
        end
        cgc_pkg::CGC_RX: begin
          if (scl_r && q_q.bcnt != 4'h8) begin
            d_d.shr = {q_q.shr[6:0], sda};
            d_d.bcnt = q_q.bcnt + 4'h1;
          end else if (scl_f && q_q.bcnt == 4'h8) begin
            d_d.st = cgc_pkg::CGC_ACK;
            d_d.sda_oe_n = 1'b0;
            if (q_q.bno != 2'h3) begin
              d_d.bno = q_q.bno + 2'h1;
            end
            unique case (q_q.bno)
              2'h0: begin
                // No ack while the memory is busy, nor for other slaves
                if (q_q.shr[7:1] != `CGC_SLAVE_ADDR || busy) begin
                  d_d.st = cgc_pkg::CGC_WAIT;
                  d_d.sda_oe_n = 1'b1;
                end
                d_d.rd = q_q.shr[0];
                d_d.shr = `CGC_ID_BYTE;
                d_d.pend = `CGC_CMD_WRITE;
              end
              2'h1: begin
                if (q_q.shr[1:0] == `CGC_CMD_STORE ||
                    q_q.shr[1:0] == `CGC_CMD_LOAD) begin
                  d_d.pend = q_q.shr[1:0];
                end
              end
              2'h2: begin
                d_d.ptr = q_q.shr;
              end
              default: begin
                if (q_q.ptr < 8'(`CGC_NREG)) begin
                  d_d.regs[q_q.ptr[`CGC_IDX_W-1:0]] = q_q.shr;
                end
                d_d.ptr = q_q.ptr + 8'h01;
              end
            endcase
          end
        end
        cgc_pkg::CGC_ACK: begin
          if (scl_f) begin
            d_d.bcnt = 4'h0;
            if (q_q.rd) begin
              // ID byte leads the read frame
              d_d.st = cgc_pkg::CGC_TX;
              d_d.sda_oe_n = q_q.shr[7];
            end else begin
              d_d.sda_oe_n = 1'b1;
              // Store/load frames carry nothing after the command
              d_d.st = (q_q.pend != `CGC_CMD_WRITE) ?
                       cgc_pkg::CGC_WAIT : cgc_pkg::CGC_RX;
            end
          end
        end
        cgc_pkg::CGC_TX: begin
          if (scl_f) begin
            if (q_q.bcnt == 4'h7) begin
              d_d.sda_oe_n = 1'b1;
              d_d.st = cgc_pkg::CGC_MACK;
            end else begin
              d_d.bcnt = q_q.bcnt + 4'h1;
              d_d.shr = {q_q.shr[6:0], 1'b0};
              d_d.sda_oe_n = q_q.shr[6];
            end
          end
        end
        cgc_pkg::CGC_MACK: begin
          if (scl_r) begin
            // A NACK from the master ends the read
            d_d.st = sda ? cgc_pkg::CGC_WAIT : cgc_pkg::CGC_NEXT;
          end
        end
        cgc_pkg::CGC_NEXT: begin
          if (scl_f) begin
            d_d.shr = reg_at(q_q.regs, q_q.ptr);
            d_d.ptr = q_q.ptr + 8'h01;
            d_d.sda_oe_n = reg_at(q_q.regs, q_q.ptr) >> 7 != 8'h00;
            d_d.bcnt = 4'h0;
            d_d.st = cgc_pkg::CGC_TX;
          end
        end
      endcase
    end

    // Load from memory overwrites registers; bus writes are shut out
    // meanwhile because the address is not acknowledged
    if (nif.ld_we) begin
      d_d.regs[nif.idx] = nif.ld_byte;
    end

    // ****************************************
    // Configuration select
    // ****************************************
    // Reserved codes keep the last valid configuration
    if (q_q.s2[8:6] < 3'(`CGC_NCFG)) begin
      d_d.cfg = q_q.s2[8:6];
    end

    // ****************************************
    // Source monitor and switchover
    // ****************************************
    if (rise(q_q.s2, q_q.s3, 2)) begin
      d_d.lx = 4'h0;
    end else if (rise(q_q.s2, q_q.s3, 3) && !x_lost) begin
      d_d.lx = q_q.lx + 4'h1;
    end
    if (rise(q_q.s2, q_q.s3, 3)) begin
      d_d.la = 4'h0;
    end else if (rise(q_q.s2, q_q.s3, 2) && !a_lost) begin
      d_d.la = q_q.la + 4'h1;
    end

    if (!src_reg[3]) begin
      d_d.on_sec = q_q.s2[4];
    end else if (!q_q.on_sec && prim_lost && !sec_lost) begin
      d_d.on_sec = 1'b1;
    end else if (src_reg[2] && q_q.on_sec && !prim_lost) begin
      d_d.on_sec = 1'b0;
    end
    d_d.ref_aux = q_q.on_sec ^ src_reg[`CGC_SRC_PRIM];

    // ****************************************
    // Shutdown/output-enable pin
    // ****************************************
    d_d.pdn = pin_reg[`CGC_PIN_ROLE] && gate_pin;
    for (int n = 0; n < `CGC_NOUT; n++) begin
      d_d.ohz[n] = 1'b0;
      d_d.osp[n] = 1'b0;
      d_d.pin_gated_bit[n] = 1'b0;
      if (pin_reg[`CGC_PIN_ROLE] && gate_pin) begin
        d_d.osp[n] = 1'b1;
      end else if (!act_reg[n]) begin
        d_d.ohz[n] = 1'b1;
      end else if (!gate_reg[n]) begin
        d_d.pin_gated_bit[n] = 1'b1;
      end else if (pin_reg[`CGC_PIN_ROLE]) begin
        d_d.osp[n] = pin_reg[`CGC_PIN_POL];
        d_d.pin_gated_bit[n] = !pin_reg[`CGC_PIN_POL];
      end else begin
        // In this role the pin is an enable: its active level keeps the
        // output running and the opposite level suspends it
        d_d.osp[n] = !pin_active;
        d_d.pin_gated_bit[n] = pin_active;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q_q <= '0;
      q_q.st <= cgc_pkg::CGC_IDLE;
      q_q.sda_oe_n <= 1'b1;
      q_q.ohz <= '1;
    end else begin
      q_q <= d_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: only ever pulls low
  assign O_SDA = 1'b0;
  assign O_SDA_OE_N = q_q.sda_oe_n;
  assign O_CFG_PICK = q_q.cfg;
  assign O_XTAL_BYPASS = src_reg[`CGC_SRC_BYP];
  assign O_REF_AUX = q_q.ref_aux;
  assign O_ON_SECONDARY = q_q.on_sec;
  assign O_PLL_SHUTDOWN = q_q.pdn;
  assign O_OUT_EN = q_q.pin_gated_bit;
  assign O_OUT_HIZ = q_q.ohz;
  assign O_OUT_SUSP = q_q.osp;
  assign O_NVM_BUSY = nif.busy;

endmodule // cgc_ctrl

// *** testbench/cgc_ctrl_chk.sv ***
// Concurrent checks on the ports of the clock generator control block.
// Assumes one system clock domain with an active-low async reset.
`timescale 1ns/1ps
`include "cgc_defines.svh"

module cgc_ctrl_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SHDN_GATE,
  input wire logic [2:0] I_CFG_PICK,
  input wire logic O_SDA_OE_N,
  input wire logic [2:0] O_CFG_PICK,
  input wire logic O_PLL_SHUTDOWN,
  input wire logic O_ON_SECONDARY,
  input wire logic [`CGC_NOUT-1:0] O_OUT_EN,
  input wire logic [`CGC_NOUT-1:0] O_OUT_HIZ,
  input wire logic [`CGC_NOUT-1:0] O_OUT_SUSP,
  input wire logic O_NVM_BUSY
);
  // ****************************************
  // Helper: length of the current busy run
  // ****************************************
  logic [12:0] busy_cnt_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      busy_cnt_q <= 13'h0000;
    else
      busy_cnt_q <= O_NVM_BUSY ? busy_cnt_q + 13'h0001 : 13'h0000;
  end

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // ****************************************
  // Assertions
  // ****************************************
  glob_all_susp_a: assert property (
    O_PLL_SHUTDOWN |-> &O_OUT_SUSP)
    else $error("shutdown with an output not suspended");
  out_one_state_a: assert property (
    ((O_OUT_EN ^ O_OUT_HIZ ^ O_OUT_SUSP) &
     ~(O_OUT_EN & O_OUT_HIZ & O_OUT_SUSP)) == '1)
    else $error("output not in exactly one state");
  no_shut_low_a: assert property (
    !I_SHDN_GATE [*5] |-> !O_PLL_SHUTDOWN)
    else $error("shutdown while gate pin low");
  // Two synchroniser stages plus the output flop: the pin level that
  // raised the flag was sampled three edges back
  shut_rise_a: assert property (
    $rose(O_PLL_SHUTDOWN) |-> $past(I_SHDN_GATE, 3))
    else $error("shutdown rose without gate pin high");
  busy_no_ack_a: assert property (O_NVM_BUSY |-> O_SDA_OE_N)
    else $error("data line driven during memory operation");
  busy_len_a: assert property (
    $fell(O_NVM_BUSY) |-> busy_cnt_q inside {[13'h0f96:13'h0faa]})
    else $error("memory operation length off");
  ack_scl_low_a: assert property ($changed(O_SDA_OE_N) |-> !$past(I_SCL, 2))
    else $error("data line changed while clock high");
  cfg_apply_a: assert property (
    $stable(I_CFG_PICK) [*5] ##0 (I_CFG_PICK < 3'h6) |->
    O_CFG_PICK == I_CFG_PICK)
    else $error("selected configuration not applied");
  cfg_resv_hold_a: assert property (
    (I_CFG_PICK > 3'h5) [*4] |-> $stable(O_CFG_PICK))
    else $error("reserved select code changed configuration");

  cover property ($fell(O_NVM_BUSY));
  cover property ($rose(O_PLL_SHUTDOWN));
  cover property ($rose(O_ON_SECONDARY));
endmodule // cgc_ctrl_chk

bind cgc_ctrl cgc_ctrl_chk u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_SCL(I_SCL),
  .I_SHDN_GATE(I_SHDN_GATE), .I_CFG_PICK(I_CFG_PICK),
  .O_SDA_OE_N(O_SDA_OE_N), .O_CFG_PICK(O_CFG_PICK),
  .O_PLL_SHUTDOWN(O_PLL_SHUTDOWN), .O_ON_SECONDARY(O_ON_SECONDARY),
  .O_OUT_EN(O_OUT_EN), .O_OUT_HIZ(O_OUT_HIZ), .O_OUT_SUSP(O_OUT_SUSP),
  .O_NVM_BUSY(O_NVM_BUSY)
);

// *** testbench/cgc_i2c_host.sv ***
// I2C master model for the clock generator control block.
// Assumes the data line is open drain with a pull-up resolved outside.
`timescale 1ns/1ps

module cgc_i2c_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  // ****************************************
  // Bit timing: quarter bit is two clocks
  // ****************************************
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  task automatic q(input int n);
    repeat (2 * n) @(negedge i_clk);
  endtask

  // Also serves as repeated start straight after an ack
  task automatic start();
    q(1);
    o_sda_oe_n = 1'b1;
    q(1);
    o_scl = 1'b1;
    q(1);
    o_sda_oe_n = 1'b0;
    q(2);
    o_scl = 1'b0;
  endtask

  // Sampled at the end of the high phase so slow answers still count
  task automatic bit_io(input logic b, output logic r);
    q(1);
    o_sda_oe_n = b;
    q(1);
    o_scl = 1'b1;
    q(2);
    r = i_sda;
    o_scl = 1'b0;
  endtask

  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask

  task automatic stop();
    q(1);
    o_sda_oe_n = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(1);
    o_sda_oe_n = 1'b1;
    q(1);
  endtask
endmodule // cgc_i2c_host

// *** testbench/testbench.sv ***
// Self-checking bench for the clock generator control block.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ps
`include "cgc_defines.svh"

module testbench;
  logic sys_clk, rst_n, scl, m_oe_n, sda, o_sda, sda_oe_n;
  logic xref, aux, pick, gate, xr_run, xbyp, ref_aux, on_sec, pdn, busy;
  logic [2:0] cfg, cfg_out, ph;
  logic [`CGC_NOUT-1:0] en, hiz, susp;
  int n_mismatch, cmp_count;

  assign sda = m_oe_n & (sda_oe_n | o_sda);

  cgc_ctrl dut (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_SCL(scl),
    .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_N(sda_oe_n),
    .I_XREF_CLK(xref), .I_AUX_CLK(aux), .I_SRC_PICK(pick),
    .I_SHDN_GATE(gate), .I_CFG_PICK(cfg), .O_CFG_PICK(cfg_out),
    .O_XTAL_BYPASS(xbyp), .O_REF_AUX(ref_aux), .O_ON_SECONDARY(on_sec),
    .O_PLL_SHUTDOWN(pdn), .O_OUT_EN(en), .O_OUT_HIZ(hiz),
    .O_OUT_SUSP(susp), .O_NVM_BUSY(busy));

  cgc_i2c_host host (.i_clk(sys_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe_n(m_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Reference clocks; the crystal one can be stopped to force a loss
  always @(negedge sys_clk) begin
    ph <= ph + 3'h1;
    if (ph[1:0] == 2'h0) xref <= xref ^ xr_run;
    if (ph[1:0] == 2'h2) aux <= ~aux;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp_ack);
    logic a;
    host.wr(b, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d, int n);
    host.start();
    wb(8'hd4, 1'b1);
    wb(8'h00, 1'b1);
    wb(a, 1'b1);
    for (int i = 0; i < n; i++) wb(d[31-8*i -: 8], 1'b1);
    host.stop();
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic rreg(input logic [7:0] a, input logic set, input int n,
                      input logic [31:0] e);
    logic [7:0] b;
    if (set) begin
      host.start();
      wb(8'hd4, 1'b1);
      wb(8'h00, 1'b1);
      wb(a, 1'b1);
    end
    host.start();
    wb(8'hd5, 1'b1);
    host.rd(1'b0, b);
    chk(b, `CGC_ID_BYTE);
    for (int i = 0; i < n; i++) begin
      host.rd(i == n - 1, b);
      chk(b, e[31-8*i -: 8]);
    end
    host.stop();
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge sys_clk);
    if (k == 5000) begin
      n_mismatch++;
      conclude();
    end
  endtask

  // Memory stays busy after the command, so the address is not acknowledged
  task automatic nvm_cmd(input logic [7:0] c);
    host.start();
    wb(8'hd4, 1'b1);
    wb(c, 1'b1);
    host.stop();
    repeat (8) @(negedge sys_clk);
    chk({7'h00, busy}, 8'h01);
    host.start();
    wb(8'hd4, 1'b0);
    host.stop();
    wait_idle();
  endtask

  task automatic wait_sec(input logic v);
    int k;
    for (k = 0; k < 400 && on_sec !== v; k++) @(negedge sys_clk);
    chk({7'h00, on_sec}, {7'h00, v});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power();
    chk({7'h00, busy}, 8'h01);
    host.start();
    wb(8'hd4, 1'b0);
    host.stop();
    wait_idle();
    chk({3'h0, hiz}, 8'h1f);
    host.start();
    wb(8'hd6, 1'b0);
    host.stop();
    $display("test power done");
  endtask

  task automatic t_nvm();
    wreg(8'h03, 32'ha1b2c3d4, 4);
    rreg(8'h03, 1'b1, 3, 32'ha1b2c300);
    rreg(8'h00, 1'b0, 1, 32'hd4000000);
    nvm_cmd(8'hfd);
    wreg(8'h03, 32'h00000000, 4);
    nvm_cmd(8'h52);
    rreg(8'h03, 1'b1, 4, 32'ha1b2c3d4);
    $display("test memory done");
  endtask

  task automatic t_pins();
    logic g;
    logic [4:0] s;
    logic [4:0] z;
    wreg(8'h08, 32'h0f1f0000, 2);
    wreg(8'h10, 32'h03000000, 1);
    for (int c = 0; c < 8; c++) begin
      if (!c[0]) wreg(8'h02, {6'h00, c[2], c[1], 24'h000000}, 1);
      gate = c[0];
      repeat (6) @(negedge sys_clk);
      g = c[2] & c[0];
      s = g ? 5'h1f : 5'h03 & {5{c[0] != c[1]}};
      z = g ? 5'h00 : 5'h10;
      chk({3'h0, susp}, {3'h0, s});
      chk({3'h0, hiz}, {3'h0, z});
      chk({3'h0, en}, {3'h0, ~(s | z)});
      chk({7'h00, pdn}, {7'h00, g});
    end
    gate = 1'b0;
    cfg = 3'h1;
    repeat (6) @(negedge sys_clk);
    chk({3'h0, en}, 8'h1f);
    cfg = 3'h6;
    repeat (6) @(negedge sys_clk);
    chk({5'h00, cfg_out}, 8'h01);
    cfg = 3'h0;
    $display("test pins done");
  endtask

  task automatic t_src();
    for (int c = 0; c < 4; c++) begin
      wreg(8'h00, {6'h00, c[1], c[1], 24'h000000}, 1);
      pick = c[0];
      repeat (6) @(negedge sys_clk);
      chk({7'h00, ref_aux}, {7'h00, c[1] ^ c[0]});
      chk({7'h00, xbyp}, {7'h00, c[1]});
    end
    pick = 1'b0;
    wreg(8'h00, 32'h08000000, 1);
    wait_sec(1'b0);
    xr_run = 1'b0;
    wait_sec(1'b1);
    // Reference choice is registered from the secondary flag
    @(negedge sys_clk);
    chk({7'h00, ref_aux}, 8'h01);
    xr_run = 1'b1;
    repeat (200) @(negedge sys_clk);
    chk({7'h00, on_sec}, 8'h01);
    wreg(8'h00, 32'h0c000000, 1);
    wait_sec(1'b0);
    $display("test source done");
  endtask

  initial begin
    rst_n = 1'b0;
    pick = 1'b0;
    gate = 1'b0;
    cfg = 3'h0;
    xref = 1'b0;
    aux = 1'b0;
    ph = 3'h0;
    xr_run = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_power();
    t_nvm();
    t_pins();
    t_src();
    conclude();
  end
endmodule // testbench
